// File: hw/slmm_pkg.sv
// constants and types shared by the serial link maintenance controller
// Contract
// - after master clear, terminal ready is driven and held until an error
// - any fatal or procedure error drops terminal ready
// - data set ready falling while running reports disconnect code 100 octal
// - after base, start raises send request, waits clear-to-send and ready
// - carrier detect from the modem is never used
// - send request drops about one bit before a trailing acknowledge
// - maintenance mode keeps modem control, framing and checksum handling
// - maintenance messages checked, never sequenced, acknowledged or resent
// - maintenance messages are sent and accepted only in maintenance state
// - control-in with bits 8 and 10 both set enters maintenance state
// - maintenance message while running reports maint received, is dropped
// - start sent once per second after base, stopped by maintenance mode
// - illegal procedure error copies 200 octal bytes to host address 0
// - control-in, buffer or invalid command before base is an illegal error
// - table updates write only internal locations below 200 octal; the code writes any of the 256 except the two flag bytes
// - receive descriptor: five bytes, assigned flag bit 0 of byte 1
// - transmit descriptor: six bytes, assigned bit 0, transmitted bit 1
package slmm_pkg;
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned CLK_NS = 25;
  localparam int unsigned START_PERIOD_MS = 1000;
  localparam int unsigned START_CYC = START_PERIOD_MS * (CLK_HZ / 1000);
  localparam int unsigned BIT_TIME_NS = 1000;
  localparam int unsigned RTS_DROP_CYC = (BIT_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_CTLIN = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_REPORT = 8'h0C;
  localparam logic [7:0] REG_MEMADDR = 8'h10;
  localparam logic [7:0] REG_MEMDATA = 8'h14;
  localparam logic [7:0] REG_BASE = 8'h18;
  localparam logic [1:0] CMD_BUF = 2'h0;
  localparam logic [1:0] CMD_CTLIN = 2'h1;
  localparam logic [1:0] CMD_INVALID = 2'h2;
  localparam logic [1:0] CMD_BASE = 2'h3;
  localparam int unsigned CMD_DIR_BIT = 2;
  localparam int unsigned MAINT_MODE_BIT = 8;
  localparam int unsigned HALF_DUPLEX_BIT = 10;
  localparam logic [7:0] RPT_DISCONNECT = 8'h40;
  localparam logic [7:0] RPT_MAINT_RECD = 8'h08;
  localparam int unsigned MEM_WORDS = 256;
  localparam logic [6:0] DUMP_LAST = 7'h7F;
  localparam logic [7:0] RXD_BASE = 8'h14;
  localparam logic [7:0] TXD_BASE = 8'h39;
  localparam int unsigned FLAG_ASSIGNED = 0;
  localparam int unsigned FLAG_SENT = 1;
  localparam logic [1:0] TXK_START = 2'h0;
  localparam logic [1:0] TXK_DATA = 2'h1;
  localparam logic [1:0] TXK_MAINT = 2'h2;
  localparam logic [1:0] TXK_ACK = 2'h3;

  typedef struct packed {
    logic [7:0] flags;
    logic [7:0] addr_lo;
    logic [7:0] addr_hi;
    logic [7:0] ext_cnt_hi;
    logic [7:0] cnt_lo;
  } slmm_rxd_t;

  typedef struct packed {
    logic [7:0] flags;
    logic [7:0] msg_num;
    logic [7:0] addr_lo;
    logic [7:0] addr_hi;
    logic [7:0] ext_cnt_hi;
    logic [7:0] cnt_lo;
  } slmm_txd_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } slmm_wb_req_t;

  typedef struct packed {
    logic req;
    logic [17:0] addr;
    logic [7:0] data;
  } slmm_dma_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01, ST_START = 5'h02, ST_RUN = 5'h04,
    ST_MAINT = 5'h08, ST_HALT = 5'h10
  } slmm_state_t;

  typedef enum logic [4:0] {
    TX_IDLE = 5'h01, TX_WAIT = 5'h02, TX_SEND = 5'h04,
    TX_NEXT = 5'h08, TX_GAP = 5'h10
  } slmm_tx_t;
endpackage : slmm_pkg

// File: hw/slmm_ctrl.sv
// serial link controller: modem control, maintenance mode, error dump
`timescale 1ns/100ps
`default_nettype none
module slmm_ctrl #(
  parameter int unsigned START_CYCLES = slmm_pkg::START_CYC,
  parameter int unsigned RTS_DROP_CYCLES = slmm_pkg::RTS_DROP_CYC
) (
  input wire logic CLK_IN,
  input wire logic NRST_IN,
  input wire slmm_pkg::slmm_wb_req_t WB_REQ_IN,
  output logic WB_ACK_OUT,
  output logic [31:0] WB_DAT_OUT,
  output logic DTR_OUT,
  output logic RTS_OUT,
  input wire logic CTS_IN,
  input wire logic MODEM_READY_IN,
  input wire logic DSR_IN,
  output logic TX_REQ_OUT,
  output logic [1:0] TX_KIND_OUT,
  output var slmm_pkg::slmm_txd_t TX_DESC_OUT,
  input wire logic TX_DONE_IN,
  input wire logic STARTUP_DONE_IN,
  input wire logic RX_MSG_IN,
  input wire logic RX_MAINT_IN,
  input wire logic RX_CRC_OK_IN,
  output logic RX_ACCEPT_OUT,
  output var slmm_pkg::slmm_rxd_t RX_DESC_OUT,
  output var slmm_pkg::slmm_dma_t DMA_OUT,
  input wire logic DMA_ACK_IN
);
  if (START_CYCLES < 2 || START_CYCLES >= 2**30 || RTS_DROP_CYCLES < 1 ||
      RTS_DROP_CYCLES > 1000) begin : g_bad_param
    $error("slmm_ctrl: timing parameter out of range");
  end

  slmm_pkg::slmm_state_t st_r, st_nxt;
  slmm_pkg::slmm_tx_t tx_st_r, tx_st_nxt;
  logic [7:0] mem [0:slmm_pkg::MEM_WORDS-1];
  logic wb_ack_r;
  logic [31:0] wb_dat_r, rd_val;
  logic [31:0] ctlin_word_r;
  logic [17:0] base_addr_r, dump_base_r;
  logic [7:0] mem_addr_r, rpt_code_r, rxf_nxt, txf_nxt;
  logic base_r, ctlin_r, dtr_r, dsr_q_r, rpt_valid_r;
  logic start_due_r, ack_pend_r, tx_req_r, rx_accept_r;
  logic [29:0] start_cnt_r;
  logic [9:0] gap_cnt_r;
  logic [1:0] tx_kind_r;
  logic [6:0] dump_idx_r;
  slmm_pkg::slmm_txd_t txd, txd_out_r;
  slmm_pkg::slmm_rxd_t rxd, rxd_out_r;
  slmm_pkg::slmm_dma_t dma_r;

  function automatic logic [31:0] merge_lanes(input logic [31:0] old_v,
      input logic [31:0] new_v, input logic [3:0] sel);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) res[8*i +: 8] = new_v[8*i +: 8];
    end
    return res;
  endfunction : merge_lanes

  function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
    return adr == off;
  endfunction : hit

  // bus slave: ack one cycle after the request, writes land on the ack edge
  wire logic bus_sel = WB_REQ_IN.cyc & WB_REQ_IN.stb;
  wire logic bus_fire = bus_sel & wb_ack_r;
  wire logic bus_wr = bus_fire & WB_REQ_IN.we;
  wire logic [7:0] adr = WB_REQ_IN.adr;
  wire logic wr_cmd = bus_wr & hit(adr, slmm_pkg::REG_CMD) & WB_REQ_IN.sel[0];
  wire logic rd_rpt = bus_fire & ~WB_REQ_IN.we &
                      hit(adr, slmm_pkg::REG_REPORT);
  wire logic [1:0] cmd_code = WB_REQ_IN.dat[1:0];
  wire logic cmd_rx = WB_REQ_IN.dat[slmm_pkg::CMD_DIR_BIT];
  wire logic live = st_r != slmm_pkg::ST_HALT;

  // command decode and error classes
  wire logic illegal = wr_cmd & ~base_r &
                       (cmd_code != slmm_pkg::CMD_BASE);
  wire logic rebase = wr_cmd & base_r & live &
                      (cmd_code == slmm_pkg::CMD_BASE);
  wire logic do_base = wr_cmd & ~base_r & (cmd_code == slmm_pkg::CMD_BASE);
  wire logic do_ctlin = wr_cmd & base_r & live &
                        (cmd_code == slmm_pkg::CMD_CTLIN);
  wire logic maint_req = do_ctlin & ctlin_word_r[slmm_pkg::MAINT_MODE_BIT] &
                         ctlin_word_r[slmm_pkg::HALF_DUPLEX_BIT];
  wire logic buf_cmd = wr_cmd & base_r & live &
                       (cmd_code == slmm_pkg::CMD_BUF);
  // carrier detect is deliberately not an input; only dsr, cts and ready count
  wire logic dsr_fall = dsr_q_r & ~DSR_IN;
  wire logic disc = (st_r == slmm_pkg::ST_RUN) & dsr_fall;
  wire logic mrecd = (st_r == slmm_pkg::ST_RUN) & RX_MSG_IN &
                     RX_MAINT_IN;
  wire logic err_any = illegal | rebase | disc | mrecd;

  // descriptors: first receive and first transmit entry of the table
  assign rxd = {mem[slmm_pkg::RXD_BASE], mem[slmm_pkg::RXD_BASE + 8'h01],
                mem[slmm_pkg::RXD_BASE + 8'h02],
                mem[slmm_pkg::RXD_BASE + 8'h03],
                mem[slmm_pkg::RXD_BASE + 8'h04]};
  assign txd = {mem[slmm_pkg::TXD_BASE], mem[slmm_pkg::TXD_BASE + 8'h01],
                mem[slmm_pkg::TXD_BASE + 8'h02],
                mem[slmm_pkg::TXD_BASE + 8'h03],
                mem[slmm_pkg::TXD_BASE + 8'h04],
                mem[slmm_pkg::TXD_BASE + 8'h05]};
  wire logic txd_ready = txd.flags[slmm_pkg::FLAG_ASSIGNED];
  wire logic rxd_ready = rxd.flags[slmm_pkg::FLAG_ASSIGNED];

  // receive: maintenance messages only in maintenance state, checksum gated
  wire logic rx_take = RX_MSG_IN & RX_MAINT_IN & RX_CRC_OK_IN & rxd_ready &
                       (st_r == slmm_pkg::ST_MAINT);
  wire logic rx_data_ok = RX_MSG_IN & ~RX_MAINT_IN & RX_CRC_OK_IN &
                          (st_r == slmm_pkg::ST_RUN);

  // transmit job selection
  wire logic job_start = (st_r == slmm_pkg::ST_START) & start_due_r;
  wire logic job_data = (st_r == slmm_pkg::ST_RUN) & txd_ready;
  wire logic job_maint = (st_r == slmm_pkg::ST_MAINT) &
                         txd_ready;
  wire logic job_ack = (st_r == slmm_pkg::ST_RUN) & ack_pend_r;
  wire logic job_any = job_start | job_data | job_maint | job_ack;
  wire logic [1:0] job_kind = job_start ? slmm_pkg::TXK_START :
                              job_data ? slmm_pkg::TXK_DATA :
                              job_maint ? slmm_pkg::TXK_MAINT :
                              slmm_pkg::TXK_ACK;
  wire logic tx_abort = ~live |
      ((tx_kind_r == slmm_pkg::TXK_START) & (st_r != slmm_pkg::ST_START)) |
      ((tx_kind_r == slmm_pkg::TXK_MAINT) & (st_r != slmm_pkg::ST_MAINT)) |
      ((tx_kind_r != slmm_pkg::TXK_MAINT) & (tx_kind_r != slmm_pkg::TXK_START)
       & (st_r != slmm_pkg::ST_RUN));
  wire logic tx_done = (tx_st_r == slmm_pkg::TX_SEND) & TX_DONE_IN & ~tx_abort;
  wire logic tx_mark = tx_done & ((tx_kind_r == slmm_pkg::TXK_DATA) |
                                  (tx_kind_r == slmm_pkg::TXK_MAINT));
  wire logic start_tick = (st_r == slmm_pkg::ST_START) &
                          (start_cnt_r == 30'(START_CYCLES - 1));
  wire logic gap_last = gap_cnt_r == 10'(RTS_DROP_CYCLES - 1);
  wire logic [6:0] dump_inc = dump_idx_r + 7'h01;
  wire logic mem_wr = bus_wr & hit(adr, slmm_pkg::REG_MEMDATA) &
                      WB_REQ_IN.sel[0] & (mem_addr_r != slmm_pkg::RXD_BASE) &
                      (mem_addr_r != slmm_pkg::TXD_BASE);

  // flag bytes: hardware sets beat software clears in the same cycle
  always_comb begin
    rxf_nxt = mem[slmm_pkg::RXD_BASE];
    if (rx_take) rxf_nxt[slmm_pkg::FLAG_ASSIGNED] = 1'b0;
    if (buf_cmd & cmd_rx) rxf_nxt[slmm_pkg::FLAG_ASSIGNED] = 1'b1;
    txf_nxt = mem[slmm_pkg::TXD_BASE];
    if (tx_mark) txf_nxt[slmm_pkg::FLAG_ASSIGNED] = 1'b0;
    if (buf_cmd & ~cmd_rx) begin
      txf_nxt[slmm_pkg::FLAG_ASSIGNED] = 1'b1;
      txf_nxt[slmm_pkg::FLAG_SENT] = 1'b0;
    end
    if (tx_mark) txf_nxt[slmm_pkg::FLAG_SENT] = 1'b1;
  end

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      slmm_pkg::ST_IDLE: if (do_base) st_nxt = slmm_pkg::ST_START;
      slmm_pkg::ST_START: begin
        if (maint_req) st_nxt = slmm_pkg::ST_MAINT;
        else if (ctlin_r & STARTUP_DONE_IN) st_nxt = slmm_pkg::ST_RUN;
      end
      slmm_pkg::ST_RUN: if (maint_req) st_nxt = slmm_pkg::ST_MAINT;
      slmm_pkg::ST_MAINT: st_nxt = slmm_pkg::ST_MAINT;
      slmm_pkg::ST_HALT: st_nxt = slmm_pkg::ST_HALT;
      default: st_nxt = slmm_pkg::ST_IDLE;
    endcase
    if (err_any) st_nxt = slmm_pkg::ST_HALT;
  end

  always_comb begin
    tx_st_nxt = tx_st_r;
    case (tx_st_r)
      slmm_pkg::TX_IDLE: if (job_any) tx_st_nxt = slmm_pkg::TX_WAIT;
      slmm_pkg::TX_WAIT: begin
        if (tx_abort) tx_st_nxt = slmm_pkg::TX_IDLE;
        else if (CTS_IN & MODEM_READY_IN)
          tx_st_nxt = slmm_pkg::TX_SEND;
      end
      slmm_pkg::TX_SEND: begin
        if (tx_abort) tx_st_nxt = slmm_pkg::TX_IDLE;
        else if (TX_DONE_IN) tx_st_nxt = slmm_pkg::TX_NEXT;
      end
      slmm_pkg::TX_NEXT: begin
        if (tx_kind_r == slmm_pkg::TXK_DATA & job_data)
          tx_st_nxt = slmm_pkg::TX_WAIT;
        else if (tx_kind_r == slmm_pkg::TXK_DATA & job_ack)
          tx_st_nxt = slmm_pkg::TX_GAP;
        else tx_st_nxt = slmm_pkg::TX_IDLE;
      end
      slmm_pkg::TX_GAP: begin
        if (tx_abort) tx_st_nxt = slmm_pkg::TX_IDLE;
        else if (gap_last) tx_st_nxt = slmm_pkg::TX_WAIT;
      end
      default: tx_st_nxt = slmm_pkg::TX_IDLE;
    endcase
  end

  always_comb begin
    case (adr)
      slmm_pkg::REG_CTLIN: rd_val = ctlin_word_r;
      slmm_pkg::REG_STATUS: rd_val = {16'h0000, ack_pend_r, dma_r.req, ctlin_r,
                                      base_r, RTS_OUT, dtr_r, tx_st_r, st_r};
      slmm_pkg::REG_REPORT: rd_val = {23'h00_0000, rpt_valid_r, rpt_code_r};
      slmm_pkg::REG_MEMADDR: rd_val = {24'h00_0000, mem_addr_r};
      slmm_pkg::REG_MEMDATA: rd_val = {24'h00_0000, mem[mem_addr_r]};
      slmm_pkg::REG_BASE: rd_val = {14'h0000, base_addr_r};
      default: rd_val = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLK_IN) begin
    if (!NRST_IN) begin
      for (int i = 0; i < slmm_pkg::MEM_WORDS; i++) mem[i] <= 8'h00;
    end else begin
      if (mem_wr) mem[mem_addr_r] <= WB_REQ_IN.dat[7:0];
      mem[slmm_pkg::RXD_BASE] <= rxf_nxt;
      mem[slmm_pkg::TXD_BASE] <= txf_nxt;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!NRST_IN) begin
      wb_ack_r <= 1'b0;
      wb_dat_r <= 32'h0000_0000;
      ctlin_word_r <= 32'h0000_0000;
      base_addr_r <= 18'h0_0000;
      mem_addr_r <= 8'h00;
    end else begin
      wb_ack_r <= bus_sel & ~wb_ack_r;
      if (bus_sel & ~wb_ack_r) wb_dat_r <= rd_val;
      if (bus_wr & hit(adr, slmm_pkg::REG_CTLIN))
        ctlin_word_r <= merge_lanes(ctlin_word_r, WB_REQ_IN.dat,
                                    WB_REQ_IN.sel);
      if (bus_wr & hit(adr, slmm_pkg::REG_BASE))
        base_addr_r <= 18'(merge_lanes({14'h0000, base_addr_r}, WB_REQ_IN.dat,
                                       WB_REQ_IN.sel));
      if (bus_wr & hit(adr, slmm_pkg::REG_MEMADDR) & WB_REQ_IN.sel[0])
        mem_addr_r <= WB_REQ_IN.dat[7:0];
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!NRST_IN) begin
      st_r <= slmm_pkg::ST_IDLE;
      base_r <= 1'b0;
      ctlin_r <= 1'b0;
      dtr_r <= 1'b1;
      dsr_q_r <= 1'b0;
      rpt_valid_r <= 1'b0;
      rpt_code_r <= 8'h00;
    end else begin
      st_r <= st_nxt;
      base_r <= base_r | do_base;
      ctlin_r <= ctlin_r | do_ctlin;
      dsr_q_r <= DSR_IN;
      if (err_any) dtr_r <= 1'b0;
      if (disc | mrecd) rpt_code_r <= disc ? slmm_pkg::RPT_DISCONNECT :
                                 slmm_pkg::RPT_MAINT_RECD;
      rpt_valid_r <= disc | mrecd | (rpt_valid_r & ~rd_rpt);
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!NRST_IN) begin
      tx_st_r <= slmm_pkg::TX_IDLE;
      tx_kind_r <= slmm_pkg::TXK_START;
      tx_req_r <= 1'b0;
      txd_out_r <= '0;
      start_cnt_r <= '0;
      start_due_r <= 1'b0;
      gap_cnt_r <= '0;
      ack_pend_r <= 1'b0;
    end else begin
      tx_st_r <= tx_st_nxt;
      if (tx_st_r == slmm_pkg::TX_IDLE & job_any) tx_kind_r <= job_kind;
      if (tx_st_nxt == slmm_pkg::TX_GAP) tx_kind_r <= slmm_pkg::TXK_ACK;
      tx_req_r <= (tx_st_r == slmm_pkg::TX_WAIT) &
                  (tx_st_nxt == slmm_pkg::TX_SEND);
      if (tx_st_nxt == slmm_pkg::TX_SEND) txd_out_r <= txd;
      start_cnt_r <= (st_r != slmm_pkg::ST_START | start_tick) ? '0 :
                     start_cnt_r + 30'h0000_0001;
      start_due_r <= do_base | start_tick | (start_due_r & job_start &
                     ~(tx_st_r == slmm_pkg::TX_IDLE));
      gap_cnt_r <= (tx_st_r == slmm_pkg::TX_GAP) ? gap_cnt_r + 10'h001 : '0;
      ack_pend_r <= rx_data_ok | (ack_pend_r & ~(tx_done &
                    (tx_kind_r == slmm_pkg::TXK_ACK)) & live);
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!NRST_IN) begin
      rx_accept_r <= 1'b0;
      rxd_out_r <= '0;
      dma_r <= '0;
      dump_idx_r <= 7'h00;
      dump_base_r <= 18'h0_0000;
    end else begin
      rx_accept_r <= rx_take;
      if (rx_take) rxd_out_r <= rxd;
      if ((illegal | rebase) & ~dma_r.req) begin
        dma_r.req <= 1'b1;
        dma_r.addr <= illegal ? 18'h0_0000 : base_addr_r;
        dma_r.data <= mem[0];
        dump_idx_r <= 7'h00;
        dump_base_r <= illegal ? 18'h0_0000 : base_addr_r;
      end else if (dma_r.req & DMA_ACK_IN) begin
        if (dump_idx_r == slmm_pkg::DUMP_LAST) dma_r.req <= 1'b0;
        dump_idx_r <= dump_inc;
        dma_r.addr <= dump_base_r + {11'h000, dump_inc};
        dma_r.data <= mem[{1'b0, dump_inc}];
      end
    end
  end

  assign WB_ACK_OUT = wb_ack_r;
  assign WB_DAT_OUT = wb_dat_r;
  assign DTR_OUT = dtr_r;
  assign RTS_OUT = (tx_st_r == slmm_pkg::TX_WAIT) |
                   (tx_st_r == slmm_pkg::TX_SEND) |
                   (tx_st_r == slmm_pkg::TX_NEXT);
  assign TX_REQ_OUT = tx_req_r;
  assign TX_KIND_OUT = tx_kind_r;
  assign TX_DESC_OUT = txd_out_r;
  assign RX_ACCEPT_OUT = rx_accept_r;
  assign RX_DESC_OUT = rxd_out_r;
  assign DMA_OUT = dma_r;

  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!NRST_IN);

  sequence gap_enter;
    tx_st_r == slmm_pkg::TX_GAP && $past(tx_st_r) == slmm_pkg::TX_NEXT;
  endsequence
  sequence modem_ok;
    CTS_IN && MODEM_READY_IN && RTS_OUT;
  endsequence

  dtr_hold_a: assert property (DTR_OUT && !err_any |=> DTR_OUT)
    else $error("terminal ready dropped without error");
  dtr_drop_a: assert property (err_any |=> !DTR_OUT [*2])
    else $error("terminal ready kept after error");
  disc_report_a: assert property (disc |=> rpt_valid_r &&
      rpt_code_r == slmm_pkg::RPT_DISCONNECT && st_r == slmm_pkg::ST_HALT)
    else $error("disconnect not reported");
  send_modem_a: assert property (TX_REQ_OUT |->
      $past(CTS_IN && MODEM_READY_IN && RTS_OUT))
    else $error("frame sent without modem handshake");
  gap_low_a: assert property (gap_enter |-> (!RTS_OUT && !TX_REQ_OUT)
      until (tx_st_r != slmm_pkg::TX_GAP))
    else $error("send request high during gap");
  gap_bound_a: assert property (gap_enter |-> ##[1:1000] modem_ok or
      tx_st_r != slmm_pkg::TX_GAP)
    else $error("gap never ends");
  maint_only_a: assert property (RX_ACCEPT_OUT |-> $past(st_r ==
      slmm_pkg::ST_MAINT && RX_MAINT_IN && RX_CRC_OK_IN))
    else $error("message accepted outside maintenance");
  no_ack_maint_a: assert property (TX_REQ_OUT &&
      TX_KIND_OUT == slmm_pkg::TXK_ACK |-> $past(st_r == slmm_pkg::ST_RUN))
    else $error("acknowledge sent outside running state");
  maint_enter_a: assert property (maint_req && !err_any |=>
      st_r == slmm_pkg::ST_MAINT)
    else $error("maintenance state not entered");
  maint_recd_a: assert property (mrecd |=> rpt_valid_r &&
      !RX_ACCEPT_OUT && rpt_code_r == slmm_pkg::RPT_MAINT_RECD)
    else $error("maint received not reported");
  start_stop_a: assert property (st_r == slmm_pkg::ST_MAINT |->
      !(TX_REQ_OUT && TX_KIND_OUT == slmm_pkg::TXK_START))
    else $error("start sent in maintenance");
  dump_zero_a: assert property (illegal && !dma_r.req |=>
      DMA_OUT.req && DMA_OUT.addr == 18'h0_0000)
    else $error("illegal error dump not at zero");
  dump_limit_a: assert property (DMA_OUT.req |->
      (DMA_OUT.addr - dump_base_r) < 18'h0_0080)
    else $error("dump beyond internal table limit");
endmodule : slmm_ctrl
`default_nettype wire

// File: dv/slmm_modem_model.sv
// modem and framer model: clear-to-send delay, frame done, dma ack
`timescale 1ns/100ps
`default_nettype none
module slmm_modem_model (
  input wire logic CLK_IN,
  input wire logic NRST_IN,
  input wire logic RTS_IN,
  input wire logic TX_REQ_IN,
  input wire logic DMA_REQ_IN,
  output logic CTS_OUT,
  output logic READY_OUT,
  output logic TX_DONE_OUT,
  output logic DMA_ACK_OUT
);
  logic [2:0] cts_sr_r;
  logic [3:0] tx_sr_r;
  always_ff @(posedge CLK_IN) begin
    if (!NRST_IN) begin
      cts_sr_r <= '0;
      tx_sr_r <= '0;
      DMA_ACK_OUT <= 1'b0;
      READY_OUT <= 1'b0;
    end else begin
      cts_sr_r <= {cts_sr_r[1:0], RTS_IN};
      tx_sr_r <= {tx_sr_r[2:0], TX_REQ_IN};
      DMA_ACK_OUT <= DMA_REQ_IN && !DMA_ACK_OUT;
      READY_OUT <= 1'b1;
    end
  end
  // clear-to-send drops at once when send request is released
  assign CTS_OUT = cts_sr_r[2] & RTS_IN;
  assign TX_DONE_OUT = tx_sr_r[3];
endmodule : slmm_modem_model
`default_nettype wire

// File: dv/serial_link_modem_maint_ctrl_tb_top.sv
// testbench: bus access, modem control, maintenance and dump checks
`timescale 1ns/100ps
`default_nettype none
module serial_link_modem_maint_ctrl_tb_top;
  logic clk = 0, nrst = 0, dsr = 1, sup = 0, rxm = 0, rxmt = 0;
  logic ack, dtr, rts, cts, rdy, txreq, txdone, rxacc, dack;
  logic [1:0] kind;
  logic [31:0] rdat, q;
  slmm_pkg::slmm_wb_req_t req = '0;
  slmm_pkg::slmm_txd_t txd;
  slmm_pkg::slmm_rxd_t rxd;
  slmm_pkg::slmm_dma_t dma;
  logic [17:0] dbase = '0;
  int n_mismatch = 0, cmp_count = 0, n_dma = 0;
  bit hit;
  always #12.5 clk = ~clk;
  slmm_ctrl #(.START_CYCLES(50), .RTS_DROP_CYCLES(4)) slmm_ctrl_i (
    .CLK_IN(clk), .NRST_IN(nrst), .WB_REQ_IN(req), .WB_ACK_OUT(ack),
    .WB_DAT_OUT(rdat), .DTR_OUT(dtr), .RTS_OUT(rts), .CTS_IN(cts),
    .MODEM_READY_IN(rdy), .DSR_IN(dsr), .TX_REQ_OUT(txreq),
    .TX_KIND_OUT(kind), .TX_DESC_OUT(txd), .TX_DONE_IN(txdone),
    .STARTUP_DONE_IN(sup), .RX_MSG_IN(rxm), .RX_MAINT_IN(rxmt),
    .RX_CRC_OK_IN(1'b1), .RX_ACCEPT_OUT(rxacc), .RX_DESC_OUT(rxd),
    .DMA_OUT(dma), .DMA_ACK_IN(dack));
  slmm_modem_model slmm_modem_model_i (
    .CLK_IN(clk), .NRST_IN(nrst), .RTS_IN(rts), .TX_REQ_IN(txreq),
    .DMA_REQ_IN(dma.req), .CTS_OUT(cts), .READY_OUT(rdy),
    .TX_DONE_OUT(txdone), .DMA_ACK_OUT(dack));
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : test_done
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask : cmp
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] r);
    int i;
    i = 0;
    @(posedge clk);
    req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hF, dat: d};
    do @(posedge clk); while (ack !== 1'b1 && ++i < 20);
    r = rdat;
    req <= '0;
    if (i >= 20) begin
      n_mismatch++;
      test_done();
    end
  endtask : wb
  // 0 start frame, 1 receive accepted, 2 dma idle, 3 acknowledge frame
  task automatic wev(input int w, input int lim, output bit h);
    int i;
    for (i = 0; i < lim; i++) begin
      @(posedge clk);
      if ((w == 0 && txreq === 1'b1 && kind === slmm_pkg::TXK_START) ||
          (w == 1 && rxacc === 1'b1) || (w == 2 && dma.req === 1'b0) ||
          (w == 3 && txreq === 1'b1 && kind === slmm_pkg::TXK_ACK))
        break;
    end
    h = i < lim;
  endtask : wev
  task automatic rst;
    @(posedge clk);
    nrst <= 1'b0;
    dsr <= 1'b1;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    n_dma = 0;
  endtask : rst
  task automatic rx_maint(input logic m);
    @(posedge clk);
    rxm <= 1'b1;
    rxmt <= m;
    @(posedge clk);
    rxm <= 1'b0;
  endtask : rx_maint
  task automatic base_up(input logic [31:0] ctl);
    wb(1'b1, slmm_pkg::REG_BASE, 32'h0000_0100, q);
    wb(1'b1, slmm_pkg::REG_CMD, 32'(slmm_pkg::CMD_BASE), q);
    wb(1'b1, slmm_pkg::REG_CTLIN, ctl, q);
    wb(1'b1, slmm_pkg::REG_CMD, 32'(slmm_pkg::CMD_CTLIN), q);
  endtask : base_up
  task automatic run_up;
    base_up(32'h0000_0000);
    @(posedge clk);
    sup <= 1'b1;
    @(posedge clk);
    sup <= 1'b0;
    wb(1'b0, slmm_pkg::REG_STATUS, 32'h0000_0000, q);
    cmp(q[4:0], 5'h04);
  endtask : run_up
  always @(posedge clk) begin
    if (dma.req === 1'b1 && dack === 1'b1) begin
      cmp(32'(dma.addr), 32'(dbase) + n_dma);
      n_dma++;
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    cmp(dtr, 1'b1);
    cmp(rts, 1'b0);
    wb(1'b1, slmm_pkg::REG_CMD, 32'(slmm_pkg::CMD_CTLIN), q);
    repeat (3) @(posedge clk);
    wev(2, 600, hit);
    cmp(hit, 1'b1);
    cmp(n_dma, 128);
    cmp(dtr, 1'b0);
    rst();
    wb(1'b1, slmm_pkg::REG_BASE, 32'h0000_0100, q);
    wb(1'b1, slmm_pkg::REG_CMD, 32'(slmm_pkg::CMD_BASE), q);
    wev(0, 100, hit);
    cmp({hit, rts, cts, rdy}, 4'hF);
    wev(0, 200, hit);
    cmp(hit, 1'b1);
    wb(1'b1, slmm_pkg::REG_CTLIN, 32'h0000_0500, q);
    wb(1'b1, slmm_pkg::REG_CMD, 32'(slmm_pkg::CMD_CTLIN), q);
    wb(1'b0, slmm_pkg::REG_STATUS, 32'h0000_0000, q);
    cmp(q[4:0], 5'h08);
    wev(0, 200, hit);
    cmp(hit, 1'b0);
    wb(1'b1, slmm_pkg::REG_CMD, 32'h0000_0004, q);
    rx_maint(1'b1);
    wev(1, 20, hit);
    cmp(hit, 1'b1);
    cmp(rxd.flags[0], 1'b1);
    wb(1'b0, 8'hFC, 32'h0000_0000, q);
    cmp(q, 32'h0000_0000);
    // second base command: dump from the table base, link dropped
    dbase = 18'h0_0100;
    wb(1'b1, slmm_pkg::REG_CMD, 32'(slmm_pkg::CMD_BASE), q);
    repeat (2) @(posedge clk);
    wev(2, 600, hit);
    cmp(hit, 1'b1);
    cmp(n_dma, 128);
    cmp(dtr, 1'b0);
    rst();
    run_up();
    rx_maint(1'b1);
    wb(1'b0, slmm_pkg::REG_REPORT, 32'h0000_0000, q);
    cmp(q[8:0], {1'b1, slmm_pkg::RPT_MAINT_RECD});
    cmp(dtr, 1'b0);
    rst();
    run_up();
    // single transmit buffer, then data received: gap before the ack
    wb(1'b1, slmm_pkg::REG_CMD, 32'h0000_0000, q);
    rx_maint(1'b0);
    wev(3, 200, hit);
    cmp(hit, 1'b1);
    wb(1'b1, slmm_pkg::REG_MEMADDR, 32'(slmm_pkg::TXD_BASE), q);
    wb(1'b0, slmm_pkg::REG_MEMDATA, 32'h0000_0000, q);
    cmp(q[1:0], 2'b10);
    @(posedge clk);
    dsr <= 1'b0;
    repeat (3) @(posedge clk);
    wb(1'b0, slmm_pkg::REG_REPORT, 32'h0000_0000, q);
    cmp(q[8:0], {1'b1, slmm_pkg::RPT_DISCONNECT});
    test_done();
  end
endmodule : serial_link_modem_maint_ctrl_tb_top
`default_nettype wire
